// File: logic/cid_map.svh
// Register map, opcode patterns, field positions and cycle counts
// Operation
// - Word 000B branches relative by the accumulator, two cycles.
// - Word 000A calls the accumulator target, pushes return address, two cycles.
// - 11 0100 kkkk kkkk returns and loads literal into accumulator, two cycles.
// - Word 0063 enters standby in one cycle, updates timeout and power-down flags.
// - 00 0000 0110 0fff copies accumulator to selected direction register, one cycle.
// - 11 0001 0nkk kkkk adds literal to pointer n in one cycle, no flags.
// - Pointer-add literal is signed, -32 to 31, added to the full 16-bit pair.
// - Pointer arithmetic wraps modulo 16 bits.
// - 00 0000 0001 0nmm reads indirect into accumulator with mm modifier, sets zero.
// - 11 1111 0nkk kkkk reads pointer plus offset into accumulator, sets zero.
// - 00 0000 0001 1nmm writes accumulator indirect with mm modifier, flags kept.
// - 11 1111 1nkk kkkk writes accumulator at pointer plus offset, flags kept.
// - Any program counter change except soft reset takes two cycles, the second one idle.
// - Indirect access with pointer top bit set adds one cycle.
// - AND literal into accumulator, zero flag only.
// - Add literal to accumulator, update carry, digit carry and zero.
// - Register AND to accumulator when d is 0, to register when 1, sets zero.
`ifndef CID_MAP_SVH
`define CID_MAP_SVH
`define CID_A_INSN      8'h00
`define CID_A_STAT      8'h04
`define CID_A_ACC       8'h08
`define CID_A_PTR0      8'h0C
`define CID_A_PTR1      8'h10
`define CID_A_PC        8'h14
`define CID_A_STACK     8'h18
`define CID_A_DIR_HI    3'h1
`define CID_ST_BUSY     0
`define CID_ST_ZERO     1
`define CID_ST_DCARRY   2
`define CID_ST_CARRY    3
`define CID_ST_PDOWN    4
`define CID_ST_TMOUT    5
`define CID_ST_BAD      6
`define CID_ST_CYC      9:8
`define CID_HTRANS_NSEQ 2'h2
`define CID_HSIZE_WORD  3'h2
`define CID_OC_NOOP     14'h0000
`define CID_OC_SRESET   14'h0001
`define CID_OC_RET      14'h0008
`define CID_OC_IRET     14'h0009
`define CID_OC_CALLACC  14'h000A
`define CID_OC_BRACC    14'h000B
`define CID_OC_STANDBY  14'h0063
`define CID_OC_WDCLR    14'h0064
`define CID_P8_RETLIT   6'h34
`define CID_P8_ADDLIT   6'h3E
`define CID_P8_ANDLIT   6'h39
`define CID_P8_ANDREG   6'h05
`define CID_P7_PTRADD   7'h62
`define CID_P7_IXRD     7'h7E
`define CID_P7_IXWR     7'h7F
`define CID_P11_DIR     11'h00C
`define CID_P11_INDRD   11'h002
`define CID_P11_INDWR   11'h003
`define CID_P9_RELBR    5'h19
`define CID_P11_CALL    3'h4
`define CID_P11_JUMP    3'h5
`define CID_CYC_ONE     2'h1
`define CID_CYC_EXTRA   2'h1
`define CID_RST_TMOUT   1'b1
`define CID_RST_PDOWN   1'b1
`endif

// File: logic/cid_pkg.sv
// Types shared by the decoder core
package cid_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_HOLD = 2'h3
	} cid_state_e;
	typedef enum logic [4:0] {
		OP_NO_OPERATION, OP_SOFT_RESET, OP_RETURN, OP_INTERRUPT_RETURN,
		OP_CALL_BY_ACCUMULATOR, OP_BRANCH_BY_ACCUMULATOR, OP_STANDBY,
		OP_WATCHDOG_CLEAR, OP_DIR_LOAD, OP_POINTER_ADD_LITERAL,
		OP_INDIRECT_READ, OP_INDIRECT_WRITE, OP_INDEXED_READ,
		OP_INDEXED_WRITE, OP_CALL, OP_ABSOLUTE_JUMP, OP_RELATIVE_BRANCH,
		OP_RETURN_WITH_LITERAL, OP_AND_LITERAL, OP_ADD_LITERAL,
		OP_AND_REGISTER, OP_UNKNOWN
	} cid_op_e;
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} cid_ahb_s;
endpackage

// File: logic/cid_ptr_step.sv
// Pointer adder wrapping modulo its width
`timescale 1ns/1ps
module cid_ptr_step #(
	parameter int W = 16
) (
	// Operands
	input  wire logic [W-1:0] base,
	input  wire logic [W-1:0] delta,
	// Result
	output logic      [W-1:0] sum
);
	assign sum = base + delta;
endmodule // cid_ptr_step

// File: logic/cid_core.sv
// Instruction decoder and executor with AHB-Lite register access
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cid_map.svh"
module cid_core #(
	parameter int STACK_DEPTH = 8,
	parameter int DATA_DEPTH  = 128
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire cid_pkg::cid_ahb_s ahb,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Core status
	output logic                   busy,
	output logic                   standby_req,
	output logic                   wdt_clear,
	output logic                   soft_reset
);
	import cid_pkg::*;

	localparam int SW = $clog2(STACK_DEPTH);
	localparam int AW = $clog2(DATA_DEPTH);

	cid_state_e  state;
	cid_state_e  next_state;
	cid_op_e     op;
	logic [13:0] ir;
	logic [7:0]  acc;
	logic [15:0] ptr [2];
	logic [14:0] pc;
	logic [14:0] stack [STACK_DEPTH];
	logic [SW-1:0] sp;
	logic [7:0]  data_mem [DATA_DEPTH];
	logic [7:0]  pin_direction_register [8];
	logic        zero_flag;
	logic        carry_flag;
	logic        digit_carry_flag;
	logic        timeout_flag;
	logic        power_down_flag;
	logic        bad_op;
	logic [1:0]  last_cycles;

	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        addr_ok;
	logic        bw;
	logic [31:0] rd_mux;
	logic        exec;

	logic        sel;
	logic [15:0] cur_ptr;
	logic [15:0] ptr_lit;
	logic [15:0] ptr_step;
	logic [15:0] ind_addr;
	logic [7:0]  ind_rd;
	logic [7:0]  reg_rd;
	logic        is_ind;
	logic        is_indexed;
	logic        pc_mod;
	logic        slow_ind;
	logic [1:0]  cycles;
	logic [14:0] pc_inc;
	logic [14:0] next_pc;
	logic        push;
	logic        pop;
	logic [8:0]  add_sum;
	logic [4:0]  nib_sum;
	logic [7:0]  and_lit;
	logic [7:0]  and_reg;

	// Opcode classification, exact words before patterns
	always_comb begin
		op = OP_UNKNOWN;
		if (ir == `CID_OC_NOOP)
			op = OP_NO_OPERATION;
		else if (ir == `CID_OC_SRESET)
			op = OP_SOFT_RESET;
		else if (ir == `CID_OC_RET)
			op = OP_RETURN;
		else if (ir == `CID_OC_IRET)
			op = OP_INTERRUPT_RETURN;
		else if (ir == `CID_OC_CALLACC)
			op = OP_CALL_BY_ACCUMULATOR;
		else if (ir == `CID_OC_BRACC)
			op = OP_BRANCH_BY_ACCUMULATOR;
		else if (ir == `CID_OC_STANDBY)
			op = OP_STANDBY;
		else if (ir == `CID_OC_WDCLR)
			op = OP_WATCHDOG_CLEAR;
		else if (ir[13:3] == `CID_P11_DIR)
			op = OP_DIR_LOAD;
		else if (ir[13:3] == `CID_P11_INDRD)
			op = OP_INDIRECT_READ;
		else if (ir[13:3] == `CID_P11_INDWR)
			op = OP_INDIRECT_WRITE;
		else if (ir[13:7] == `CID_P7_PTRADD)
			op = OP_POINTER_ADD_LITERAL;
		else if (ir[13:7] == `CID_P7_IXRD)
			op = OP_INDEXED_READ;
		else if (ir[13:7] == `CID_P7_IXWR)
			op = OP_INDEXED_WRITE;
		else if (ir[13:9] == `CID_P9_RELBR)
			op = OP_RELATIVE_BRANCH;
		else if (ir[13:11] == `CID_P11_CALL)
			op = OP_CALL;
		else if (ir[13:11] == `CID_P11_JUMP)
			op = OP_ABSOLUTE_JUMP;
		else if (ir[13:8] == `CID_P8_RETLIT)
			op = OP_RETURN_WITH_LITERAL;
		else if (ir[13:8] == `CID_P8_ANDLIT)
			op = OP_AND_LITERAL;
		else if (ir[13:8] == `CID_P8_ADDLIT)
			op = OP_ADD_LITERAL;
		else if (ir[13:8] == `CID_P8_ANDREG)
			op = OP_AND_REGISTER;
	end

	// Pointer selection and effective address
	assign is_ind     = (op == OP_INDIRECT_READ) || (op == OP_INDIRECT_WRITE);
	assign is_indexed = (op == OP_INDEXED_READ) || (op == OP_INDEXED_WRITE);
	assign sel        = is_ind ? ir[2] : ir[6];
	assign cur_ptr    = ptr[sel];

	cid_ptr_step #(
		.W (16)
	) u_lit (
		.base  (cur_ptr),
		.delta ({{10{ir[5]}}, ir[5:0]}),
		.sum   (ptr_lit)
	);

	cid_ptr_step #(
		.W (16)
	) u_step (
		.base  (cur_ptr),
		.delta (ir[0] ? 16'hFFFF : 16'h0001),
		.sum   (ptr_step)
	);

	// Modifier: bit 1 selects post, bit 0 selects decrement
	assign ind_addr = is_indexed ? ptr_lit : (ir[1] ? cur_ptr : ptr_step);
	assign ind_rd   = data_mem[ind_addr[AW-1:0]];
	assign reg_rd   = data_mem[AW'(ir[6:0])];

	// Cycle count per instruction
	assign pc_mod = (op == OP_CALL) || (op == OP_ABSOLUTE_JUMP) ||
		(op == OP_RELATIVE_BRANCH) || (op == OP_BRANCH_BY_ACCUMULATOR) ||
		(op == OP_CALL_BY_ACCUMULATOR) || (op == OP_RETURN) ||
		(op == OP_INTERRUPT_RETURN) || (op == OP_RETURN_WITH_LITERAL);
	assign slow_ind = (is_ind || is_indexed) && cur_ptr[15];
	assign cycles   = `CID_CYC_ONE + (pc_mod ? `CID_CYC_EXTRA : 2'h0) +
		(slow_ind ? `CID_CYC_EXTRA : 2'h0);

	// Arithmetic
	assign add_sum = {1'b0, acc} + {1'b0, ir[7:0]};
	assign nib_sum = {1'b0, acc[3:0]} + {1'b0, ir[3:0]};
	assign and_lit = acc & ir[7:0];
	assign and_reg = acc & reg_rd;

	// Program counter flow
	assign pc_inc = pc + 15'h0001;
	assign push   = (op == OP_CALL) || (op == OP_CALL_BY_ACCUMULATOR);
	assign pop    = (op == OP_RETURN) || (op == OP_INTERRUPT_RETURN) ||
		(op == OP_RETURN_WITH_LITERAL);

	always_comb begin
		next_pc = pc_inc;
		unique case (op)
			OP_CALL, OP_ABSOLUTE_JUMP: begin
				next_pc = {pc[14:11], ir[10:0]};
			end
			OP_RELATIVE_BRANCH: begin
				next_pc = pc_inc + {{6{ir[8]}}, ir[8:0]};
			end
			OP_BRANCH_BY_ACCUMULATOR: begin
				next_pc = pc_inc + {7'h00, acc};
			end
			OP_CALL_BY_ACCUMULATOR: begin
				next_pc = {pc[14:8], acc};
			end
			OP_RETURN, OP_INTERRUPT_RETURN, OP_RETURN_WITH_LITERAL: begin
				next_pc = stack[sp - SW'(1)];
			end
			OP_SOFT_RESET: begin
				next_pc = 15'h0000;
			end
			default: begin
				next_pc = pc_inc;
			end
		endcase
	end

	// AHB-Lite address phase
	assign addr_ok = ahb.hsel && ahb.hready && (ahb.htrans == `CID_HTRANS_NSEQ) &&
		(ahb.hsize == `CID_HSIZE_WORD);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (ahb.haddr[31:8] == 24'h00_0000) begin
			if (ahb.haddr[7:5] == `CID_A_DIR_HI)
				rd_mux = {24'h00_0000, pin_direction_register[ahb.haddr[4:2]]};
			else begin
				unique case (ahb.haddr[7:0])
					`CID_A_INSN:  rd_mux = {18'h0_0000, ir};
					`CID_A_ACC:   rd_mux = {24'h00_0000, acc};
					`CID_A_PTR0:  rd_mux = {16'h0000, ptr[0]};
					`CID_A_PTR1:  rd_mux = {16'h0000, ptr[1]};
					`CID_A_PC:    rd_mux = {17'h0_0000, pc};
					`CID_A_STACK: rd_mux = 32'(sp);
					`CID_A_STAT: begin
						rd_mux[`CID_ST_BUSY]   = (state != ST_IDLE);
						rd_mux[`CID_ST_ZERO]   = zero_flag;
						rd_mux[`CID_ST_DCARRY] = digit_carry_flag;
						rd_mux[`CID_ST_CARRY]  = carry_flag;
						rd_mux[`CID_ST_PDOWN]  = power_down_flag;
						rd_mux[`CID_ST_TMOUT]  = timeout_flag;
						rd_mux[`CID_ST_BAD]    = bad_op;
						rd_mux[`CID_ST_CYC]    = last_cycles;
					end
					default: rd_mux = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= addr_ok && ahb.hwrite && (ahb.haddr[31:8] == 24'h00_0000);
			wr_addr   <= ahb.haddr[7:0];
			hrdata    <= (addr_ok && !ahb.hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Data phase write, taken only while idle
	assign bw   = wr_pend && (state == ST_IDLE);
	assign exec = (state == ST_EXEC);

	// Sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (bw && wr_addr == `CID_A_INSN) next_state = ST_EXEC;
			ST_EXEC: next_state = (cycles > `CID_CYC_ONE) ? ST_HOLD : ST_IDLE;
			ST_HOLD: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state       <= ST_IDLE;
			busy        <= 1'b0;
			last_cycles <= 2'h0;
		end else begin
			state <= next_state;
			busy  <= (next_state != ST_IDLE);
			if (exec)
				last_cycles <= cycles;
		end
	end

	// Instruction register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ir <= `CID_OC_NOOP;
		else if (bw && wr_addr == `CID_A_INSN)
			ir <= ahb.hwdata[13:0];
	end

	// Accumulator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			acc <= 8'h00;
		else if (bw && wr_addr == `CID_A_ACC)
			acc <= ahb.hwdata[7:0];
		else if (exec) begin
			unique case (op)
				OP_INDIRECT_READ, OP_INDEXED_READ: acc <= ind_rd;
				OP_RETURN_WITH_LITERAL: acc <= ir[7:0];
				OP_AND_LITERAL: acc <= and_lit;
				OP_ADD_LITERAL: acc <= add_sum[7:0];
				OP_AND_REGISTER: if (!ir[7]) acc <= and_reg;
				OP_SOFT_RESET: acc <= 8'h00;
				default: acc <= acc;
			endcase
		end
	end

	// Status flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_flag        <= 1'b0;
			carry_flag       <= 1'b0;
			digit_carry_flag <= 1'b0;
			timeout_flag     <= `CID_RST_TMOUT;
			power_down_flag  <= `CID_RST_PDOWN;
		end else if (exec) begin
			unique case (op)
				OP_INDIRECT_READ, OP_INDEXED_READ: zero_flag <= (ind_rd == 8'h00);
				OP_AND_LITERAL: zero_flag <= (and_lit == 8'h00);
				OP_AND_REGISTER: zero_flag <= (and_reg == 8'h00);
				OP_ADD_LITERAL: begin
					zero_flag        <= (add_sum[7:0] == 8'h00);
					carry_flag       <= add_sum[8];
					digit_carry_flag <= nib_sum[4];
				end
				OP_STANDBY: begin
					timeout_flag    <= 1'b1;
					power_down_flag <= 1'b0;
				end
				OP_WATCHDOG_CLEAR: begin
					timeout_flag    <= 1'b1;
					power_down_flag <= 1'b1;
				end
				default: zero_flag <= zero_flag;
			endcase
		end
	end

	// Pointer pairs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr[0] <= 16'h0000;
			ptr[1] <= 16'h0000;
		end else if (bw && wr_addr == `CID_A_PTR0)
			ptr[0] <= ahb.hwdata[15:0];
		else if (bw && wr_addr == `CID_A_PTR1)
			ptr[1] <= ahb.hwdata[15:0];
		else if (exec) begin
			if (op == OP_POINTER_ADD_LITERAL)
				ptr[sel] <= ptr_lit;
			else if (is_ind)
				ptr[sel] <= ptr_step;
			else if (op == OP_SOFT_RESET) begin
				ptr[0] <= 16'h0000;
				ptr[1] <= 16'h0000;
			end
		end
	end

	// Program counter and return stack
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= 15'h0000;
			sp <= '0;
		end else if (bw && wr_addr == `CID_A_PC)
			pc <= ahb.hwdata[14:0];
		else if (exec) begin
			pc <= next_pc;
			if (op == OP_SOFT_RESET)
				sp <= '0;
			else if (push)
				sp <= sp + SW'(1);
			else if (pop)
				sp <= sp - SW'(1);
		end
	end

	always_ff @(posedge hclk) begin
		if (exec && push)
			stack[sp] <= pc_inc;
	end

	// Data memory
	always_ff @(posedge hclk) begin
		if (exec) begin
			if (op == OP_INDIRECT_WRITE || op == OP_INDEXED_WRITE)
				data_mem[ind_addr[AW-1:0]] <= acc;
			else if (op == OP_AND_REGISTER && ir[7])
				data_mem[AW'(ir[6:0])] <= and_reg;
		end
	end

	// Direction registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 8; i++)
				pin_direction_register[i] <= 8'hFF;
		end else if (exec && op == OP_DIR_LOAD)
			pin_direction_register[ir[2:0]] <= acc;
	end

	// Side effects and error flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			standby_req <= 1'b0;
			wdt_clear   <= 1'b0;
			soft_reset  <= 1'b0;
			bad_op      <= 1'b0;
		end else begin
			wdt_clear  <= exec && (op == OP_WATCHDOG_CLEAR);
			soft_reset <= exec && (op == OP_SOFT_RESET);
			if (exec && op == OP_STANDBY)
				standby_req <= 1'b1;
			else if (bw && wr_addr == `CID_A_INSN)
				standby_req <= 1'b0;
			if (exec && op == OP_UNKNOWN)
				bad_op <= 1'b1;
			else if (bw && wr_addr == `CID_A_INSN)
				bad_op <= 1'b0;
		end
	end
endmodule // cid_core

// File: testbench/cid_core_asserts.sv
// Concurrent checks on the decoder core ports
`timescale 1ns/1ps
module cid_core_asserts (
	// Clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// Bus side
	input wire cid_pkg::cid_ahb_s ahb,
	input wire logic [31:0]       hrdata,
	input wire logic              hreadyout,
	input wire logic              hresp,
	// Status
	input wire logic              busy,
	input wire logic              standby_req,
	input wire logic              wdt_clear,
	input wire logic              soft_reset
);
	import cid_pkg::*;
	logic        wr_q;
	logic        st;
	logic [13:0] w;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Instruction write taken in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= ahb.hsel && ahb.hready && ahb.htrans == 2'h2 && ahb.hsize == 3'h2 && ahb.hwrite
				&& ahb.haddr == 32'h0;
		end
	end
	assign w = ahb.hwdata[13:0];
	assign st = wr_q && !busy;
	sequence s_one;
		busy ##1 !busy;
	endsequence
	sequence s_two;
		busy [*2] ##1 !busy;
	endsequence
	a_accum_branch_two: assert property (st && w == 14'h000B |=> s_two)
		else $error("branch by accumulator length wrong");
	a_accum_call_two: assert property (st && w == 14'h000A |=> s_two)
		else $error("call by accumulator length wrong");
	a_lit_return_two: assert property (st && w[13:8] == 6'h34 |=> s_two)
		else $error("return with literal length wrong");
	a_return_two: assert property (st && w[13:1] == 13'h0004 |=> s_two)
		else $error("return length wrong");
	a_abs_target_two: assert property (st && w[13:12] == 2'h2 |=> s_two)
		else $error("call or jump length wrong");
	a_rel_branch_two: assert property (st && w[13:9] == 5'h19 |=> s_two)
		else $error("relative branch length wrong");
	a_dir_load_one: assert property (st && w[13:3] == 11'h00C |=> s_one)
		else $error("direction load length wrong");
	a_ptr_add_one: assert property (st && w[13:7] == 7'h62 |=> s_one)
		else $error("pointer add length wrong");
	a_and_lit_one: assert property (st && w[13:8] == 6'h39 |=> s_one)
		else $error("and literal length wrong");
	a_add_lit_one: assert property (st && w[13:8] == 6'h3E |=> s_one)
		else $error("add literal length wrong");
	a_standby_req: assert property (st && w == 14'h0063 |=> ##1 standby_req)
		else $error("standby request missing");
	a_wdt_pulse: assert property (st && w == 14'h0064 |=> ##1 wdt_clear ##1 !wdt_clear)
		else $error("watchdog clear pulse wrong");
	a_reset_pulse: assert property (st && w == 14'h0001 |=> ##1 soft_reset ##1 !soft_reset)
		else $error("software reset pulse wrong");
endmodule // cid_core_asserts

bind cid_core cid_core_asserts u_asserts (.hclk(hclk), .hresetn(hresetn), .ahb(ahb), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .busy(busy), .standby_req(standby_req), .wdt_clear(wdt_clear),
	.soft_reset(soft_reset));

// File: testbench/cid_prog_mem.sv
// Program memory model holding the instruction words of the cycle sweep
`timescale 1ns/1ps
module cid_prog_mem (
	// Word index
	input  wire logic [3:0]  idx,
	// Instruction word
	output logic      [13:0] word
);
	localparam logic [13:0] ROM [16] = '{14'h0000, 14'h0064, 14'h0061, 14'h3100, 14'h0500, 14'h3900,
		14'h3E00, 14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h3412, 14'h2000, 14'h2800, 14'h3200, 14'h0001};
	assign word = ROM[idx];
endmodule // cid_prog_mem

// File: testbench/tb.sv
// Self-checking bench for the decoder core
`timescale 1ns/1ps
module tb;
	import cid_pkg::*;
	localparam logic [15:0] TWO = 16'h7F80;
	logic        hclk;
	logic        hresetn;
	cid_ahb_s    m;
	cid_ahb_s    ahb_in;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        busy;
	logic        standby_req;
	logic        wdt_clear;
	logic        soft_reset;
	logic [3:0]  pidx;
	logic [13:0] pword;
	int          miscompares;
	int          checks;
	always #4 hclk = ~hclk;
	always_comb begin
		ahb_in = m;
		ahb_in.hready = hreadyout;
	end
	cid_core dut (.hclk(hclk), .hresetn(hresetn), .ahb(ahb_in), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .busy(busy), .standby_req(standby_req), .wdt_clear(wdt_clear), .soft_reset(soft_reset));
	cid_prog_mem prog (.idx(pidx), .word(pword));
	task automatic complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	// Single transfer, entered and left at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		m <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: 2'h2, hwrite: wr, hsize: 3'h2, hwdata: 32'h0, hready: 1'b0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		m.htrans <= 2'h0;
		m.hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp, what);
	endtask
	// Counts edges until busy drops
	task automatic idle(output int n);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (busy === 1'b1 && n < 8);
	endtask
	task automatic exec(input logic [13:0] w, input int cyc);
		int n;
		wr(8'h00, {18'h0, w});
		idle(n);
		check(n - 1, cyc, "cycles");
	endtask
	task automatic t_reset;
		rd_chk(8'h04, 32'h30, "status");
		rd_chk(8'h20, 32'hFF, "direction 0");
		rd_chk(8'h1C, 32'h0, "unmapped");
	endtask
	task automatic t_cycles;
		for (int i = 0; i < 16; i++) begin
			pidx <= i[3:0];
			@(posedge hclk);
			exec(pword, 1 + TWO[i]);
		end
	endtask
	task automatic t_ptr_add;
		exec(14'h3900, 1);
		wr(8'h0C, 32'h0005);
		exec(14'h3120, 1);
		rd_chk(8'h0C, 32'hFFE5, "ptr0 minus 32");
		wr(8'h10, 32'hFFF0);
		exec(14'h315F, 1);
		rd_chk(8'h10, 32'h000F, "ptr1 wrap");
		rd_chk(8'h04, 32'h132, "flags kept");
	endtask
	task automatic t_indirect;
		wr(8'h0C, 32'h20);
		wr(8'h08, 32'h11);
		exec(14'h0018, 1);
		wr(8'h08, 32'h22);
		exec(14'h001B, 1);
		rd_chk(8'h0C, 32'h20, "ptr0 after writes");
		exec(14'h0010, 1);
		exec(14'h0012, 1);
		exec(14'h0011, 1);
		exec(14'h0013, 1);
		rd_chk(8'h08, 32'h22, "acc indirect");
		rd_chk(8'h0C, 32'h20, "ptr0 after reads");
		wr(8'h10, 32'h8003);
		wr(8'h08, 32'h00);
		exec(14'h3FC1, 2);
		rd_chk(8'h04, 32'h230, "indexed write flags");
		exec(14'h3F41, 2);
		rd_chk(8'h04, 32'h232, "indexed read zero");
	endtask
	task automatic t_alu;
		wr(8'h08, 32'h0F);
		exec(14'h3EF1, 1);
		rd_chk(8'h04, 32'h13E, "add flags");
		wr(8'h08, 32'hF0);
		exec(14'h393C, 1);
		rd_chk(8'h08, 32'h30, "and literal");
		rd_chk(8'h04, 32'h13C, "and flags");
		wr(8'h08, 32'h26);
		exec(14'h0521, 1);
		rd_chk(8'h08, 32'h22, "and to acc");
		wr(8'h08, 32'h0D);
		exec(14'h05A1, 1);
		rd_chk(8'h08, 32'h0D, "acc kept");
		exec(14'h3F01, 1);
		rd_chk(8'h08, 32'h00, "and to register");
	endtask
	task automatic t_power;
		exec(14'h0063, 1);
		check(standby_req, 1'b1, "standby");
		rd_chk(8'h04, 32'h12E, "standby flags");
		wr(8'h08, 32'h3C);
		exec(14'h0062, 1);
		rd_chk(8'h28, 32'h3C, "direction 2");
		rd_chk(8'h3C, 32'hFF, "direction 7");
		exec(14'h0064, 1);
		rd_chk(8'h04, 32'h13E, "watchdog flags");
	endtask
	task automatic t_refuse;
		int n;
		wr(8'h08, 32'h55);
		wr(8'h00, 32'h2800);
		wr(8'h08, 32'h77);
		idle(n);
		rd_chk(8'h08, 32'h55, "write while busy");
	endtask
	// Branch, call and return targets
	task automatic t_flow;
		wr(8'h14, 32'h0100);
		exec(14'h3205, 2);
		rd_chk(8'h14, 32'h106, "branch forward");
		exec(14'h33FE, 2);
		rd_chk(8'h14, 32'h105, "branch back");
		wr(8'h08, 32'h10);
		exec(14'h000B, 2);
		rd_chk(8'h14, 32'h116, "branch by acc");
		exec(14'h000A, 2);
		rd_chk(8'h14, 32'h110, "call by acc");
		rd_chk(8'h18, 32'h1, "pushed");
		exec(14'h0008, 2);
		rd_chk(8'h14, 32'h117, "return");
		exec(14'h2123, 2);
		rd_chk(8'h14, 32'h123, "call");
		exec(14'h3440, 2);
		rd_chk(8'h08, 32'h40, "literal loaded");
		rd_chk(8'h14, 32'h118, "literal return");
		exec(14'h2C00, 2);
		rd_chk(8'h14, 32'h400, "jump");
		exec(14'h0001, 1);
		rd_chk(8'h14, 32'h0, "soft reset pc");
		rd_chk(8'h08, 32'h0, "soft reset acc");
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		m = '0;
		pidx = 4'h0;
		miscompares = 0;
		checks = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_cycles();
		t_ptr_add();
		t_indirect();
		t_alu();
		t_power();
		t_refuse();
		t_flow();
		complete_run();
	end
	initial begin
		#(20000 * 8);
		miscompares++;
		complete_run();
	end
endmodule // tb
